// [conv_seq.sv]
// conversion sequencer: start capture, channel walk, results, avalon slave, interrupts
// Function
// RULE1: a rising edge on conversion start holds all four track/holds and starts a sequence over the selected channels.
// RULE2: selection comes from the hardware pins when the source input is zero, else from the select register.
// RULE3: the selection is latched at the start edge and held for the whole sequence.
// RULE4: busy rises with the start edge and stays high for the whole sequence.
// RULE5: after the last selected channel busy falls and all track/holds return to track together.
// RULE6: every channel conversion completion is signalled on the end-of-conversion output.
// RULE7: the internal clock is used by default and the external clock input when clock source select is high.
// RULE8: with the internal clock each channel takes 1.65 us, so sequence length scales with channel count.
// RULE9: the host may read results once busy falls or one at a time after each end-of-conversion.
// RULE10: the host should not read during a conversion or in the 100 ns before the next start edge.
// RULE11: the host waits 350 ns acquisition time after a sequence ends before the next start.
// RULE12: each result is moved as one 12-bit word over the data bus.
// RULE13: the host writes the channel select register with an ordinary write on the four low data bits.
// RULE14: selected channels are converted in ascending channel order.
// RULE15: the low four write data bits land in the select register, bit 0 for channel 1 and bit 3 for channel 4.
// RULE16: each conversion end is marked by a short low pulse on the active-low end-of-conversion output.
// RULE17: a start edge that arrives while busy is high is ignored.
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module conv_seq
    import conv_seq_pkg::*;
#(
    parameter int CONV_CYC = CONV_CYCLES,
    parameter int EXT_EDG = EXT_EDGES
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // converter pins
    input wire logic conversionStart_n,
    input wire logic [NUM_CH-1:0] hwChannelPins,
    input wire logic selSource,
    input wire logic clockSourceSelect,
    input wire logic externalClockInput,
    // conversion datapath
    input wire logic [DATA_W-1:0] adcResult,
    output logic [NUM_CH-1:0] holdCh,
    output logic [1:0] convCh,
    output logic busy,
    output logic eoc_n,
    // avalon-mm slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    // interrupt
    output logic irq
);
    // selects the lowest set channel of a mask
    function automatic logic [1:0] lowestCh(input logic [NUM_CH-1:0] m);
        logic [1:0] r;
        r = 2'h0;
        for (int i = NUM_CH - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = 2'(i);
            end
        end
        return r;
    endfunction : lowestCh

    localparam int CNT_W = $clog2(CONV_CYC + 1) + 1;

    logic [NUM_CH-1:0] pinsSync;
    logic startLowSync;
    logic srcSync;
    logic clkSelSync;
    logic extClkSync;
    logic startPrev_q;
    logic extPrev_q;
    logic startEdge;
    logic extEdge;
    seq_state_t state_q;
    logic [NUM_CH-1:0] chsel_q;
    logic [NUM_CH-1:0] pending_q;
    logic useExt_q;
    logic [CNT_W-1:0] cnt_q;
    logic [1:0] eocCnt_q;
    logic [DATA_W-1:0] result_q [NUM_CH];
    logic [2:0] irqStat_q;
    logic [2:0] irqMask_q;
    logic ackPhase_q;
    logic convDone;
    logic lastCh;
    logic evEoc;
    logic evDone;
    logic evIgnored;
    logic regWrite;

    // every pin crosses two flops before use; start enters inverted so the
    // flops' reset zero reads as the idle-high pin and no false edge follows reset
    sync2 #(.W(NUM_CH + 4)) u_sync (
        .core_clk(core_clk),
        .nrst(nrst),
        .asyncIn({hwChannelPins, ~conversionStart_n, selSource, clockSourceSelect, externalClockInput}),
        .syncOut({pinsSync, startLowSync, srcSync, clkSelSync, extClkSync})
    );

    // edge history of synchronised start and external clock
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            startPrev_q <= 1'b0;
            extPrev_q <= 1'b0;
        end
        else
        begin
            startPrev_q <= startLowSync;
            extPrev_q <= extClkSync;
        end
    end

    assign startEdge = !startLowSync && startPrev_q;
    assign extEdge = extClkSync && !extPrev_q;
    // external clock counts its edges, internal counts core cycles
    assign convDone = (state_q == ST_CONV) && (useExt_q ? (extEdge && cnt_q == CNT_W'(EXT_EDG - 1))
                      : (cnt_q == CNT_W'(CONV_CYC - 1))); // RULE7 RULE8
    assign lastCh = (pending_q & ~(NUM_CH'(1) << convCh)) == '0;
    assign evEoc = convDone;
    assign evDone = convDone && lastCh;
    assign evIgnored = startEdge && busy;

    // sequence state machine
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            pending_q <= '0;
            busy <= 1'b0;
            holdCh <= '0;
            convCh <= 2'h0;
            useExt_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (startEdge) // RULE1 RULE17
                    begin
                        // latched mask only loses each finished channel until the sequence ends
                        pending_q <= srcSync ? chsel_q : pinsSync; // RULE2 RULE3
                        useExt_q <= clkSelSync; // RULE7
                        busy <= 1'b1; // RULE4
                        holdCh <= '1; // RULE1
                        state_q <= ST_PICK;
                    end
                end
                ST_PICK:
                begin
                    // an empty mask still gives one busy pulse, nothing converted
                    if (pending_q == '0)
                    begin
                        busy <= 1'b0;
                        holdCh <= '0;
                        state_q <= ST_IDLE;
                    end
                    else
                    begin
                        convCh <= lowestCh(pending_q); // RULE14
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV:
                begin
                    if (convDone)
                    begin
                        pending_q <= pending_q & ~(NUM_CH'(1) << convCh);
                        if (lastCh)
                        begin
                            busy <= 1'b0; // RULE5
                            holdCh <= '0; // RULE5
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            convCh <= lowestCh(pending_q & ~(NUM_CH'(1) << convCh)); // RULE14
                        end
                    end
                end
            endcase
        end
    end

    // per channel conversion timer
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
        end
        else if (state_q != ST_CONV || convDone)
        begin
            cnt_q <= '0;
        end
        else if (!useExt_q || extEdge)
        begin
            cnt_q <= cnt_q + CNT_W'(1); // RULE8
        end
    end

    // short low pulse at every channel end
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            eocCnt_q <= 2'h0;
            eoc_n <= 1'b1;
        end
        else if (convDone)
        begin
            eocCnt_q <= 2'(EOC_PULSE_CYCLES - 1);
            eoc_n <= 1'b0; // RULE6 RULE16
        end
        else if (eocCnt_q != 2'h0)
        begin
            eocCnt_q <= eocCnt_q - 2'h1;
        end
        else
        begin
            eoc_n <= 1'b1;
        end
    end

    // result capture per channel, one 12-bit word each
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                result_q[i] <= '0;
            end
        end
        else if (convDone)
        begin
            result_q[convCh] <= adcResult; // RULE12
        end
    end

    // one wait cycle per access keeps read data registered;
    // waitrequest is a flop, high while idle, low only in the acknowledge cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ackPhase_q <= 1'b0;
            avsWaitrequest <= 1'b1;
        end
        else
        begin
            ackPhase_q <= (avsRead || avsWrite) && !ackPhase_q;
            avsWaitrequest <= !((avsRead || avsWrite) && !ackPhase_q);
        end
    end

    assign regWrite = avsWrite && ackPhase_q;

    // channel select register and interrupt mask
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            chsel_q <= CHSEL_RESET;
            irqMask_q <= '0;
        end
        else if (regWrite)
        begin
            if (avsAddress == ADDR_CHSEL)
            begin
                chsel_q <= avsWritedata[NUM_CH-1:0]; // RULE13 RULE15
            end
            if (avsAddress == ADDR_IRQ_MASK)
            begin
                irqMask_q <= avsWritedata[2:0];
            end
        end
    end

    // sticky events, set beats write-one-to-clear
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            irqStat_q <= '0;
        end
        else
        begin
            irqStat_q <= (irqStat_q & ~((regWrite && avsAddress == ADDR_IRQ_STAT) ? avsWritedata[2:0] : 3'h0))
                         | {evIgnored, evDone, evEoc};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irqStat_q & irqMask_q);
        end
    end

    // read mux, unmapped reads zero
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            avsReaddata <= '0;
        end
        else if (avsRead && !ackPhase_q)
        begin
            if (avsAddress <= ADDR_RESULT3)
            begin
                avsReaddata <= {20'h0, result_q[avsAddress[1:0]]}; // RULE12
            end
            else if (avsAddress == ADDR_CHSEL)
            begin
                avsReaddata <= {28'h0, chsel_q};
            end
            else if (avsAddress == ADDR_STATUS)
            begin
                avsReaddata <= {24'h0, pending_q, convCh, eoc_n, busy};
            end
            else if (avsAddress == ADDR_IRQ_STAT)
            begin
                avsReaddata <= {29'h0, irqStat_q};
            end
            else if (avsAddress == ADDR_IRQ_MASK)
            begin
                avsReaddata <= {29'h0, irqMask_q};
            end
            else
            begin
                avsReaddata <= '0;
            end
        end
    end

    // busy falls in the same cycle as track/holds release
    property p_busyHold;
        @(posedge core_clk) disable iff (!nrst) busy == (holdCh == '1);
    endproperty
    a_busyHold: assert property (p_busyHold) else $error("busy and hold disagree"); // RULE5

    property p_startBusy;
        @(posedge core_clk) disable iff (!nrst) (startEdge && state_q == ST_IDLE) |=> busy && holdCh == '1;
    endproperty
    a_startBusy: assert property (p_startBusy) else $error("start did not raise busy"); // RULE4

    property p_ignore;
        @(posedge core_clk) disable iff (!nrst) (startEdge && busy) |=> $stable(pending_q) || $past(convDone);
    endproperty
    a_ignore: assert property (p_ignore) else $error("start in busy altered sequence"); // RULE17

    property p_eocPulse;
        @(posedge core_clk) disable iff (!nrst) convDone |=> !eoc_n [*2] ##1 eoc_n;
    endproperty
    a_eocPulse: assert property (p_eocPulse) else $error("eoc pulse width wrong"); // RULE16

    property p_intTime;
        @(posedge core_clk) disable iff (!nrst) (state_q == ST_CONV && !useExt_q && cnt_q == '0)
            |-> ##(CONV_CYC - 1) convDone;
    endproperty
    a_intTime: assert property (p_intTime) else $error("conversion time wrong"); // RULE8

    property p_order;
        @(posedge core_clk) disable iff (!nrst) (state_q == ST_CONV) |-> (pending_q & ((NUM_CH'(1) << convCh) - NUM_CH'(1))) == '0;
    endproperty
    a_order: assert property (p_order) else $error("channel order not ascending"); // RULE14

    property p_chsel;
        @(posedge core_clk) disable iff (!nrst) (regWrite && avsAddress == ADDR_CHSEL) |=> chsel_q == $past(avsWritedata[3:0]);
    endproperty
    a_chsel: assert property (p_chsel) else $error("select register not written"); // RULE15

    property p_src;
        @(posedge core_clk) disable iff (!nrst) (startEdge && state_q == ST_IDLE)
            |=> pending_q == ($past(srcSync) ? $past(chsel_q) : $past(pinsSync));
    endproperty
    a_src: assert property (p_src) else $error("wrong selection source"); // RULE2 RULE3
endmodule : conv_seq

// [conv_seq_pkg.sv]
// package of constants for the simultaneous sample conversion sequencer
package conv_seq_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 12;
    localparam int CLK_MHZ = 40;
    // per-channel conversion time in nanoseconds
    localparam int CONV_TIME_NS = 1650;
    localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
    // external conversion clock edges per channel (one result bit each plus overhead)
    localparam int EXT_EDGES = 14;
    localparam int EOC_PULSE_CYCLES = 2;
    // register map
    localparam logic [3:0] ADDR_RESULT0 = 4'h0;
    localparam logic [3:0] ADDR_RESULT3 = 4'h3;
    localparam logic [3:0] ADDR_CHSEL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h5;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
    localparam logic [3:0] CHSEL_RESET = 4'h0;
    localparam int IRQ_EOC_BIT = 0;
    localparam int IRQ_DONE_BIT = 1;
    localparam int IRQ_IGNORED_BIT = 2;
    typedef enum logic [1:0] {ST_IDLE, ST_PICK, ST_CONV} seq_state_t;
endpackage : conv_seq_pkg

// [sync2.sv]
// two flop synchroniser for a vector of asynchronous inputs
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // data
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);
    logic [W-1:0] stage1_q;

    // first stage feeds only the second
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            stage1_q <= '0;
            syncOut <= '0;
        end
        else
        begin
            stage1_q <= asyncIn;
            syncOut <= stage1_q;
        end
    end
endmodule : sync2

// [conv_datapath_model.sv]
// behavioural model of the converter datapath and the external conversion clock source
`timescale 1ns/1ps
module conv_datapath_model
    import conv_seq_pkg::*;
(
    // clock
    input wire logic core_clk,
    // control from bench and design
    input wire logic extClkEn,
    input wire logic [DATA_W-1:0] dataBase,
    input wire logic [1:0] convCh,
    // outputs to design
    output logic [DATA_W-1:0] adcResult,
    output logic externalClockInput
);
    logic [1:0] divCnt_q;
    // result word follows the channel under conversion so a misrouted result shows up
    assign adcResult = dataBase + {{(DATA_W-2){1'b0}}, convCh};
    initial
    begin
        externalClockInput = 1'b0;
        divCnt_q = 2'h0;
    end
    // eighth of core rate, parked low between uses so no stray edge is counted
    always @(posedge core_clk)
    begin
        if (!extClkEn)
        begin
            divCnt_q <= 2'h0;
            externalClockInput <= 1'b0;
        end
        else
        begin
            divCnt_q <= divCnt_q + 2'h1;
            if (divCnt_q == 2'h3)
                externalClockInput <= ~externalClockInput;
        end
    end
endmodule : conv_datapath_model

// [tb_conv_seq.sv]
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb_conv_seq;
    import conv_seq_pkg::*;
    localparam int CC = 8;
    localparam int EE = 4;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic conversionStart_n = 1'b1;
    logic [3:0] hwChannelPins = 4'h0;
    logic selSource = 1'b0;
    logic clockSourceSelect = 1'b0;
    logic extClkEn = 1'b0;
    logic [11:0] dataBase = 12'h000;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic externalClockInput, busy, eoc_n, irq, avsWaitrequest, irqA, irqB;
    logic [11:0] adcResult;
    logic [3:0] holdCh;
    logic [1:0] convCh, convPrev;
    logic [31:0] avsReaddata, rd;
    logic eocPrev = 1'b1;
    logic clrMon = 1'b0;
    logic [1:0] order [4];
    int errCount = 0;
    int samplesChecked = 0;
    int cyc = 0;
    int busyLen, eocCnt, lowLen, lastFall, gapRef, gapBad, badWidth, badHold, len1;

    conv_seq #(.CONV_CYC(CC), .EXT_EDG(EE)) conv_seq_i (.core_clk(core_clk), .nrst(nrst),
        .conversionStart_n(conversionStart_n), .hwChannelPins(hwChannelPins), .selSource(selSource),
        .clockSourceSelect(clockSourceSelect), .externalClockInput(externalClockInput), .adcResult(adcResult),
        .holdCh(holdCh), .convCh(convCh), .busy(busy), .eoc_n(eoc_n), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
        .avsWaitrequest(avsWaitrequest), .irq(irq));
    conv_datapath_model conv_datapath_model_i (.core_clk(core_clk), .extClkEn(extClkEn), .dataBase(dataBase),
        .convCh(convCh), .adcResult(adcResult), .externalClockInput(externalClockInput));

    // 40 MHz core clock
    initial
    begin
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic test_done;
        if (errCount == 0 && samplesChecked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
            errCount++;
        end
    endtask : check

    // avalon master: hold the request until waitrequest is seen low at a rising edge
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avsAddress <= a;
        avsWritedata <= d;
        avsWrite <= wr;
        avsRead <= ~wr;
        // values read right after the edge are the ones that edge sampled
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (avsWaitrequest !== 1'b0 && n < 50);
        if (avsWaitrequest !== 1'b0)
        begin
            errCount++;
            test_done();
        end
        rd = avsReaddata;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        // one idle edge so a following request never rises in the same step
        @(posedge core_clk);
    endtask : av_xfer

    // bounded wait for busy to reach a level, returns just after a rising edge
    task automatic wait_lvl(input logic lvl, input int lim);
        int n;
        n = 0;
        while (busy !== lvl && n < lim)
        begin
            @(negedge core_clk);
            n++;
        end
        if (busy !== lvl)
        begin
            errCount++;
            test_done();
        end
        @(posedge core_clk);
    endtask : wait_lvl

    // monitor on the falling edge, where registered outputs have settled
    always @(negedge core_clk)
    begin
        cyc++;
        if (clrMon)
        begin
            busyLen = 0;
            eocCnt = 0;
            lowLen = 0;
            gapRef = 0;
            gapBad = 0;
            badWidth = 0;
            badHold = 0;
        end
        else
        begin
            if (busy === 1'b1)
                busyLen++;
            if (holdCh !== {4{busy}})
                badHold++;
            if (eoc_n === 1'b0)
                lowLen++;
            if (eocPrev === 1'b1 && eoc_n === 1'b0)
            begin
                order[eocCnt % 4] = convPrev;
                if (eocCnt == 1)
                    gapRef = cyc - lastFall;
                else if (eocCnt > 1 && cyc - lastFall != gapRef)
                    gapBad++;
                lastFall = cyc;
                eocCnt++;
            end
            if (eocPrev === 1'b0 && eoc_n === 1'b1)
            begin
                if (lowLen != EOC_PULSE_CYCLES)
                    badWidth++;
                lowLen = 0;
            end
        end
        eocPrev = eoc_n;
        convPrev = convCh;
    end

    // one conversion sequence; mid re-pulses start and changes both selection sources while busy
    task automatic run_seq(input logic src, input logic [3:0] sel, input logic mid, input logic ext);
        int k;
        k = 0;
        repeat (14) @(posedge core_clk);
        dataBase <= dataBase + 12'h111;
        selSource <= src;
        clockSourceSelect <= ext;
        hwChannelPins <= src ? ~sel : sel;
        if (src)
            av_xfer(1'b1, ADDR_CHSEL, {28'hfffffff, sel});
        clrMon <= 1'b1;
        conversionStart_n <= 1'b0;
        @(posedge core_clk);
        clrMon <= 1'b0;
        @(posedge core_clk);
        conversionStart_n <= 1'b1;
        wait_lvl(1'b1, 6);
        if (|sel)
        begin
            av_xfer(1'b0, ADDR_STATUS, 32'h0);
            check(rd[0], 1'b1);
        end
        if (mid)
        begin
            hwChannelPins <= ~hwChannelPins;
            av_xfer(1'b1, ADDR_CHSEL, 32'h1);
            conversionStart_n <= 1'b0;
            @(posedge core_clk);
            conversionStart_n <= 1'b1;
        end
        if (ext)
        begin
            repeat (6 * CC) @(posedge core_clk);
            check(busy, 1'b1);
            extClkEn <= 1'b1;
        end
        wait_lvl(1'b0, 2000);
        extClkEn <= 1'b0;
        for (int c = 0; c < 4; c++)
        begin
            if (sel[c])
            begin
                check(order[k % 4], c);
                k++;
                av_xfer(1'b0, 4'(c), 32'h0);
                check(rd, {20'h0, dataBase + 12'(c)});
            end
        end
        check(eocCnt, k);
        check(badHold, 0);
        check(badWidth, 0);
        check(gapBad, 0);
    endtask : run_seq

    // main sequence
    initial
    begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        check({busy, eoc_n, irq, holdCh}, 32'h20);
        av_xfer(1'b0, ADDR_CHSEL, 32'h0);
        check(rd, {28'h0, CHSEL_RESET});
        av_xfer(1'b1, 4'h9, 32'hf);
        av_xfer(1'b0, 4'h8, 32'h0);
        check(rd, 32'h0);
        av_xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
        run_seq(1'b0, 4'h1, 1'b0, 1'b0);
        len1 = busyLen;
        run_seq(1'b0, 4'hf, 1'b0, 1'b0);
        check(busyLen, len1 + 3 * gapRef);
        check(gapRef >= CC && gapRef <= CC + 2, 1'b1);
        av_xfer(1'b1, ADDR_IRQ_STAT, 32'h7);
        run_seq(1'b0, 4'ha, 1'b1, 1'b0);
        av_xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h7);
        av_xfer(1'b1, ADDR_IRQ_MASK, 32'h7);
        repeat (2) @(posedge core_clk);
        irqA = irq;
        av_xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge core_clk);
        irqB = irq;
        check({irqA, irqB}, 32'h2);
        av_xfer(1'b1, ADDR_IRQ_MASK, 32'h7);
        av_xfer(1'b1, ADDR_IRQ_STAT, 32'h4);
        av_xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h3);
        av_xfer(1'b1, ADDR_IRQ_STAT, 32'h3);
        av_xfer(1'b0, ADDR_IRQ_STAT, 32'h0);
        check(rd, 32'h0);
        repeat (2) @(posedge core_clk);
        check(irq, 1'b0);
        run_seq(1'b1, 4'hd, 1'b1, 1'b0);
        run_seq(1'b1, 4'h1, 1'b0, 1'b0);
        run_seq(1'b0, 4'h0, 1'b0, 1'b0);
        run_seq(1'b0, 4'h1, 1'b0, 1'b1);
        test_done();
    end
endmodule : tb_conv_seq
